// *** include/xcv_pkg.sv ***
// Constants, types and register map of the transceiver mode controller
package xcv_pkg;
  // Mode state; Gray steps along vbat -> vcc -> normal -> go-to-sleep -> sleep
  typedef enum logic [2:0] {
    XCV_VBAT_STBY = 3'h0,
    XCV_VCC_STBY = 3'h1,
    XCV_NORMAL = 3'h3,
    XCV_GOTO_SLEEP = 3'h2,
    XCV_SLEEP = 3'h6
  } xcv_state_e;

  typedef struct packed {
    logic standby_negate_in;
    logic transfer_enable_in;
  } xcv_mode_s;

  // Bus comparator results, high = dominant or failure seen
  typedef struct packed {
    logic diff_dom;
    logic h_dom;
    logic l_dom;
    logic fail_h;
    logic fail_l;
  } xcv_bus_s;

  localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;

  localparam int ST_WAKE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_TXTO = 2;
  localparam int ST_MODE = 3;
  localparam int CTRL_TXTO_EN = 0;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic CTRL_RESET = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ = 10;
  localparam int FAIL_DELAY_US = 30;
  localparam int FAIL_DELAY_CYC = FAIL_DELAY_US * CLK_MHZ;
  localparam int TXTO_US = 1000;
  localparam int TXTO_CYC = TXTO_US * CLK_MHZ;
endpackage : xcv_pkg

// *** hdl/xcv_mode_ctrl.sv ***
// Mode, wake-up, flag and failure-fallback control of a fault-tolerant CAN transceiver
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// RQ1 - Transmit input low drives bus dominant; high leaves it recessive.
// RQ2 - Controller picks mode: 00 standby/sleep, 01 go-sleep, 10 supply standby, 11 normal.
// RQ3 - Normal mode transmits and receives; receive output low for dominant bus.
// RQ4 - Detected wiring failure switches to single-wire operation automatically.
// RQ5 - Sleep floats regulator enable, ties low termination to battery, drops pull-ups.
// RQ6 - Sleep only after go-to-sleep; later falling transfer enable changes nothing.
// RQ7 - Bus or local wake request turns regulator enable back on.
// RQ8 - Both edges of the local wake input count as wake-up.
// RQ9 - With logic supply, wake request shows low on error and receive outputs.
// RQ10 - Supply standby reports pending wake only on receive output, active low.
// RQ11 - Supply standby drives error output low while battery flag set.
// RQ12 - Battery power-on flag set on first connection to battery.
// RQ13 - Entering normal clears battery flag and returns error output high.
// RQ14 - Entering normal clears the latched wake-up indication.
// RQ15 - Supply below limit falls back to a standby mode without command.
// RQ16 - High termination follows failure logic; low termination follows failure and mode.
// RQ17 - Normal mode drives error output low while wiring failure detected.
// RQ18 - Permanent dominant transmit disables both drivers after timeout, flagged on error.
// RQ19 - Mode and wake inputs synchronised before the mode machine decodes them.
module xcv_mode_ctrl #(
  parameter int TX_TIMEOUT_CYC = xcv_pkg::TXTO_CYC
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // Controller side
  input wire logic txd_in,
  output logic rxd_out,
  output logic error_status_n,
  input wire xcv_pkg::xcv_mode_s mode_in,
  input wire logic wake_in,
  output logic txd_pullup_en,
  output logic rxd_pullup_en,
  // Supplies
  input wire logic vcc_ok,
  input wire logic vbat_ok,
  input wire logic vbat_low,
  // Bus side
  input wire xcv_pkg::xcv_bus_s bus_in,
  output logic canh_drive,
  output logic canl_drive,
  output logic high_line_termination,
  output logic low_line_term_vbat,
  output logic low_line_term_vcc,
  output logic regulator_enable_out,
  output logic regulator_enable_oe
);

  xcv_pkg::xcv_state_e state_ff, nxt_state;
  xcv_pkg::xcv_mode_s mode_s1_ff, mode_s2_ff;
  logic wake_s1_ff, wake_s2_ff, wake_s3_ff;
  logic wake_flag_ff, vbat_flag_ff, txto_ff, txto_en_ff;
  logic [1:0] sw_ff;
  logic [8:0] fail_cnt_ff [2];
  logic [13:0] txto_cnt_ff;
  logic [3:0] irq_status_ff, irq_mask_ff, evt;
  logic low_power, evt_wake, enter_normal, fail_any;
  logic nxt_rxd, nxt_err;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strb

  // Inputs are treated as synchronous, yet mode pins may move relative to each other
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_s1_ff <= '0;
      mode_s2_ff <= '0;
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
      wake_s3_ff <= 1'b0;
    end else if (clk_en) begin
      mode_s1_ff <= mode_in; // [RQ19]
      mode_s2_ff <= mode_s1_ff; // [RQ19]
      wake_s1_ff <= wake_in; // [RQ19]
      wake_s2_ff <= wake_s1_ff;
      wake_s3_ff <= wake_s2_ff;
    end
  end

  assign low_power = (state_ff != xcv_pkg::XCV_NORMAL);
  // Either edge of the local wake pin, or a dominant level on either wire
  assign evt_wake = low_power && ((wake_s2_ff ^ wake_s3_ff) || bus_in.h_dom || bus_in.l_dom); // [RQ7] [RQ8]
  assign enter_normal = (nxt_state == xcv_pkg::XCV_NORMAL) && low_power;
  assign fail_any = |sw_ff;

  always_comb begin
    nxt_state = state_ff;
    if (!vcc_ok || !vbat_ok) begin
      // Supply loss: TRANSFER_ENABLE_IN falls with VCC, so a pending sleep must not be undone
      if (state_ff == xcv_pkg::XCV_GOTO_SLEEP || state_ff == xcv_pkg::XCV_SLEEP) begin
        nxt_state = xcv_pkg::XCV_SLEEP; // [RQ6] [RQ15]
      end else begin
        nxt_state = xcv_pkg::XCV_VBAT_STBY; // [RQ15]
      end
    end else begin
      case ({mode_s2_ff.standby_negate_in, mode_s2_ff.transfer_enable_in}) // [RQ2]
        2'b00: begin
          if ((state_ff == xcv_pkg::XCV_GOTO_SLEEP || state_ff == xcv_pkg::XCV_SLEEP) && !wake_flag_ff) begin
            nxt_state = xcv_pkg::XCV_SLEEP; // [RQ6]
          end else begin
            nxt_state = xcv_pkg::XCV_VBAT_STBY; // [RQ7]
          end
        end
        2'b01: nxt_state = xcv_pkg::XCV_GOTO_SLEEP;
        2'b10: nxt_state = xcv_pkg::XCV_VCC_STBY;
        default: nxt_state = xcv_pkg::XCV_NORMAL;
      endcase
    end
    // A wake request in sleep powers the regulator even with no controller alive
    if (state_ff == xcv_pkg::XCV_SLEEP && wake_flag_ff) begin
      nxt_state = xcv_pkg::XCV_VBAT_STBY; // [RQ7]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= xcv_pkg::XCV_VBAT_STBY;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // Flags: a new event wins over the clear on normal entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_flag_ff <= 1'b0;
      vbat_flag_ff <= 1'b1; // [RQ12]
    end else if (clk_en) begin
      if (evt_wake) begin
        wake_flag_ff <= 1'b1;
      end else if (enter_normal) begin
        wake_flag_ff <= 1'b0; // [RQ14]
      end
      if (vbat_low) begin
        vbat_flag_ff <= 1'b1; // [RQ11]
      end else if (enter_normal) begin
        vbat_flag_ff <= 1'b0; // [RQ13]
      end
    end
  end

  // Filter delay keeps RF bursts from toggling single-wire mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_ff <= 2'h0;
      fail_cnt_ff[0] <= 9'h000;
      fail_cnt_ff[1] <= 9'h000;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 1 ? bus_in.fail_h : bus_in.fail_l) == sw_ff[i]) begin
          fail_cnt_ff[i] <= 9'h000;
        end else if (fail_cnt_ff[i] == 9'(xcv_pkg::FAIL_DELAY_CYC - 1)) begin
          fail_cnt_ff[i] <= 9'h000;
          sw_ff[i] <= ~sw_ff[i]; // [RQ4]
        end else begin
          fail_cnt_ff[i] <= fail_cnt_ff[i] + 9'h001;
        end
      end
    end
  end

  // Dominant watchdog; released as soon as TxD returns recessive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txto_cnt_ff <= 14'h0000;
      txto_ff <= 1'b0;
    end else if (clk_en) begin
      if (state_ff != xcv_pkg::XCV_NORMAL || txd_in || !txto_en_ff) begin
        txto_cnt_ff <= 14'h0000;
        txto_ff <= 1'b0;
      end else if (txto_cnt_ff == 14'(TX_TIMEOUT_CYC - 1)) begin
        txto_ff <= 1'b1; // [RQ18]
      end else begin
        txto_cnt_ff <= txto_cnt_ff + 14'h0001;
      end
    end
  end

  always_comb begin
    nxt_rxd = 1'b1;
    nxt_err = 1'b1;
    case (state_ff)
      xcv_pkg::XCV_NORMAL: begin
        nxt_rxd = sw_ff[1] ? !bus_in.l_dom : (sw_ff[0] ? !bus_in.h_dom : !bus_in.diff_dom); // [RQ3] [RQ4]
        nxt_err = !(fail_any || txto_ff); // [RQ17] [RQ18]
      end
      xcv_pkg::XCV_VCC_STBY: begin
        nxt_rxd = !wake_flag_ff; // [RQ10]
        nxt_err = !vbat_flag_ff; // [RQ11]
      end
      xcv_pkg::XCV_VBAT_STBY: begin
        nxt_rxd = !(wake_flag_ff && vcc_ok); // [RQ9]
        nxt_err = !(wake_flag_ff && vcc_ok); // [RQ9]
      end
      default: begin
        nxt_rxd = 1'b1;
        nxt_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxd_out <= 1'b1;
      error_status_n <= 1'b1;
      canh_drive <= 1'b0;
      canl_drive <= 1'b0;
      high_line_termination <= 1'b1;
      low_line_term_vbat <= 1'b1;
      low_line_term_vcc <= 1'b0;
      regulator_enable_oe <= 1'b1;
      txd_pullup_en <= 1'b1;
      rxd_pullup_en <= 1'b1;
    end else if (clk_en) begin
      rxd_out <= nxt_rxd;
      error_status_n <= nxt_err;
      canh_drive <= !low_power && !txd_in && !txto_ff && !sw_ff[1]; // [RQ1] [RQ3] [RQ4] [RQ18]
      canl_drive <= !low_power && !txd_in && !txto_ff && !sw_ff[0]; // [RQ1] [RQ3] [RQ4] [RQ18]
      high_line_termination <= !sw_ff[1]; // [RQ16]
      low_line_term_vbat <= !sw_ff[0] && (state_ff == xcv_pkg::XCV_VBAT_STBY ||
                            state_ff == xcv_pkg::XCV_GOTO_SLEEP || state_ff == xcv_pkg::XCV_SLEEP); // [RQ5] [RQ16]
      low_line_term_vcc <= !sw_ff[0] && (state_ff == xcv_pkg::XCV_VCC_STBY || !low_power); // [RQ16]
      regulator_enable_oe <= !(state_ff == xcv_pkg::XCV_GOTO_SLEEP || state_ff == xcv_pkg::XCV_SLEEP); // [RQ5] [RQ7]
      txd_pullup_en <= (state_ff != xcv_pkg::XCV_SLEEP); // [RQ5]
      rxd_pullup_en <= (state_ff != xcv_pkg::XCV_SLEEP); // [RQ5]
    end
  end

  assign regulator_enable_out = 1'b1;

  // Register bus; write address and data are taken together
  // Ready stays low while frozen so that no handshake is lost
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && clk_en;
  assign s_axi_wready = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid && clk_en;

  logic wr_go, rd_go;
  logic [31:0] mask_wr, ctrl_wr;
  logic i_fail_rise;
  logic fail_any_d_ff;
  assign wr_go = s_axi_awready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign mask_wr = apply_strb({28'h000_0000, irq_mask_ff}, s_axi_wdata, s_axi_wstrb);
  assign ctrl_wr = apply_strb({31'h0000_0000, txto_en_ff}, s_axi_wdata, s_axi_wstrb);
  assign i_fail_rise = fail_any && !fail_any_d_ff;

  assign evt[xcv_pkg::ST_WAKE] = evt_wake && !wake_flag_ff;
  assign evt[xcv_pkg::ST_FAIL] = i_fail_rise;
  assign evt[xcv_pkg::ST_TXTO] = (txto_cnt_ff == 14'(TX_TIMEOUT_CYC - 1)) && !txto_ff && !txd_in;
  assign evt[xcv_pkg::ST_MODE] = (nxt_state != state_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= xcv_pkg::IRQ_RESET;
      irq_mask_ff <= xcv_pkg::MASK_RESET;
      txto_en_ff <= xcv_pkg::CTRL_RESET;
      fail_any_d_ff <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= xcv_pkg::RESP_OKAY;
    end else if (clk_en) begin
      fail_any_d_ff <= fail_any;
      // Set beats the write-one-to-clear in the same cycle
      if (wr_go && s_axi_awaddr == xcv_pkg::OFS_IRQ_STATUS && s_axi_wstrb[0]) begin
        irq_status_ff <= (irq_status_ff & ~s_axi_wdata[3:0]) | evt;
      end else begin
        irq_status_ff <= irq_status_ff | evt;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= xcv_pkg::RESP_OKAY;
        if (s_axi_awaddr == xcv_pkg::OFS_IRQ_MASK) begin
          irq_mask_ff <= mask_wr[3:0];
        end else if (s_axi_awaddr == xcv_pkg::OFS_CTRL) begin
          txto_en_ff <= ctrl_wr[xcv_pkg::CTRL_TXTO_EN];
        end else if (s_axi_awaddr != xcv_pkg::OFS_IRQ_STATUS && s_axi_awaddr != xcv_pkg::OFS_STATE) begin
          s_axi_bresp <= xcv_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= xcv_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= xcv_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr == xcv_pkg::OFS_IRQ_STATUS) begin
          s_axi_rdata <= {28'h000_0000, irq_status_ff};
        end else if (s_axi_araddr == xcv_pkg::OFS_IRQ_MASK) begin
          s_axi_rdata <= {28'h000_0000, irq_mask_ff};
        end else if (s_axi_araddr == xcv_pkg::OFS_STATE) begin
          s_axi_rdata <= {21'h0_0000, mode_s2_ff, txto_ff, sw_ff, vbat_flag_ff, wake_flag_ff, 1'b0, state_ff};
        end else if (s_axi_araddr == xcv_pkg::OFS_CTRL) begin
          s_axi_rdata <= {31'h0000_0000, txto_en_ff};
        end else begin
          s_axi_rresp <= xcv_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign irq = |(irq_status_ff & irq_mask_ff);

  // Checks on the mode and pin behaviour
  sequence s_wake_in_sleep;
    state_ff == xcv_pkg::XCV_SLEEP && wake_flag_ff;
  endsequence

  sequence s_entered_sleep;
    state_ff == xcv_pkg::XCV_SLEEP && $past(state_ff) != xcv_pkg::XCV_SLEEP;
  endsequence

  AST_TX_DOMINANT: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ1]
    state_ff == xcv_pkg::XCV_NORMAL && !txd_in && !txto_ff && sw_ff == 2'h0 |=> canh_drive && canl_drive)
    else $error("dominant transmit not driven");
  AST_RXD_NORMAL: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ3]
    state_ff == xcv_pkg::XCV_NORMAL && sw_ff == 2'h0 |=> rxd_out == !$past(bus_in.diff_dom))
    else $error("receive output does not follow bus");
  AST_SINGLE_WIRE: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ4]
    sw_ff[1] |=> !canh_drive && !high_line_termination)
    else $error("failed high wire still driven");
  AST_SLEEP_PINS: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ5]
    state_ff == xcv_pkg::XCV_SLEEP && !sw_ff[0] |=> !regulator_enable_oe && low_line_term_vbat && !txd_pullup_en)
    else $error("sleep pin states wrong");
  AST_SLEEP_ENTRY: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ6]
    s_entered_sleep |-> $past(state_ff) == xcv_pkg::XCV_GOTO_SLEEP)
    else $error("sleep entered without go-to-sleep");
  AST_WAKE_REG: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ7]
    s_wake_in_sleep |-> ##2 regulator_enable_oe)
    else $error("regulator not re-enabled on wake");
  AST_WAKE_EDGE: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ8]
    low_power && (wake_s2_ff != wake_s3_ff) |=> wake_flag_ff)
    else $error("wake edge missed");
  AST_VCC_STBY_RXD: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ10]
    state_ff == xcv_pkg::XCV_VCC_STBY |=> rxd_out == !$past(wake_flag_ff))
    else $error("standby wake report wrong");
  AST_VBAT_FLAG_ERR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ11]
    state_ff == xcv_pkg::XCV_VCC_STBY && vbat_flag_ff |=> !error_status_n)
    else $error("battery flag not on error output");
  AST_NORMAL_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ13] [RQ14]
    enter_normal && !vbat_low && !evt_wake |=> !vbat_flag_ff && !wake_flag_ff)
    else $error("flags not cleared on normal entry");
  AST_FALLBACK: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ15]
    !vcc_ok |=> state_ff == xcv_pkg::XCV_VBAT_STBY || state_ff == xcv_pkg::XCV_SLEEP)
    else $error("no fallback on supply loss");
  AST_TX_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn || !clk_en) // [RQ18]
    txto_ff && state_ff == xcv_pkg::XCV_NORMAL |=> !canh_drive && !canl_drive && !error_status_n)
    else $error("drivers active after transmit timeout");

endmodule : xcv_mode_ctrl

// *** test/xcv_ctrl_model.sv ***
// Behavioural model of the CAN controller that drives the mode and transmit pins
`timescale 1ns/1ps
module xcv_ctrl_model (
  // Clock
  input wire logic aclk,
  // Requests from the test sequence
  input wire logic [1:0] req_mode,
  input wire logic req_txd,
  // Controller pins
  output xcv_pkg::xcv_mode_s mode_in,
  output logic txd_in
);
  xcv_pkg::xcv_mode_s mode_ff;
  logic txd_ff;

  // Pins move only on the clock, like a port register of a real controller
  always_ff @(posedge aclk) begin
    mode_ff <= req_mode;
    txd_ff <= req_txd;
  end

  assign mode_in = mode_ff;
  assign txd_in = txd_ff;
endmodule : xcv_ctrl_model

// *** test/xcv_mode_ctrl_tb.sv ***
// Self-checking bench for the transceiver mode controller
`timescale 1ns/1ps
module xcv_mode_ctrl_tb;
  localparam int TXTO = 64;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] data;
    logic [1:0] resp;
  } xcv_rexp_s;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] req_mode = 2'h0;
  logic req_txd = 1'b1, wake_in = 1'b0, vcc_ok = 1'b1, vbat_ok = 1'b1, vbat_low = 1'b0;
  xcv_pkg::xcv_bus_s bus_in = 5'h00;
  logic awready, wready, bvalid, arready, rvalid, irq, rxd_out, error_status_n;
  logic txd_pullup_en, rxd_pullup_en, canh_drive, canl_drive, high_line_termination;
  logic low_line_term_vbat, low_line_term_vcc, regulator_enable_oe, regulator_enable_out, txd_in;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rnd;
  xcv_pkg::xcv_mode_s mode_in;
  logic [10:0] pins;
  xcv_rexp_s rq[$];
  logic [1:0] bq[$];
  logic [21:0] pq[$];
  logic pin_chk = 1'b0;
  int mismatches = 0;
  int cmp_count = 0;
  int seed = 32'h8e08_8bf0;

  // Order: rxd, err_n, canh, canl, hterm, lterm_vbat, lterm_vcc, reg_oe, txd_pu, rxd_pu, irq
  assign pins = {rxd_out, error_status_n, canh_drive, canl_drive, high_line_termination, low_line_term_vbat,
    low_line_term_vcc, regulator_enable_oe, txd_pullup_en, rxd_pullup_en, irq};

  initial begin
    forever #50 aclk = ~aclk;
  end

  xcv_ctrl_model ctrl (.aclk(aclk), .req_mode(req_mode), .req_txd(req_txd), .mode_in(mode_in), .txd_in(txd_in));

  xcv_mode_ctrl #(.TX_TIMEOUT_CYC(TXTO)) uut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .txd_in(txd_in), .rxd_out(rxd_out), .error_status_n(error_status_n),
    .mode_in(mode_in), .wake_in(wake_in), .txd_pullup_en(txd_pullup_en), .rxd_pullup_en(rxd_pullup_en),
    .vcc_ok(vcc_ok), .vbat_ok(vbat_ok), .vbat_low(vbat_low), .bus_in(bus_in),
    .canh_drive(canh_drive), .canl_drive(canl_drive), .high_line_termination(high_line_termination),
    .low_line_term_vbat(low_line_term_vbat), .low_line_term_vcc(low_line_term_vcc),
    .regulator_enable_out(regulator_enable_out), .regulator_enable_oe(regulator_enable_oe)
  );

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  function automatic void chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected %0t %s", $time, msg);
    end
  endfunction : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc

  task automatic mode(input logic [1:0] m);
    req_mode <= m;
    wait_cyc(8);
  endtask : mode

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = xcv_pkg::RESP_OKAY);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Address and data are released independently; the slave may take them apart
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
                        input logic [1:0] er = xcv_pkg::RESP_OKAY);
    rq.push_back({m, d, er});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  // Trailing edge keeps the flag from being set and cleared in one time step
  task automatic chk_pins(input logic [10:0] m, input logic [10:0] v);
    pq.push_back({m, v});
    pin_chk <= 1'b1;
    @(posedge aclk);
    pin_chk <= 1'b0;
    @(posedge aclk);
  endtask : chk_pins

  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) begin
      chk(((rdata & rq[0].mask) === rq[0].data) && (rresp === rq[0].resp), "read word");
      void'(rq.pop_front());
    end
    if (bvalid && bready && bq.size() > 0) begin
      chk(bresp === bq[0], "write response");
      void'(bq.pop_front());
    end
    if (pin_chk && pq.size() > 0) begin
      chk((pins & pq[0][21:11]) === pq[0][10:0], "pin levels");
      chk(regulator_enable_out === 1'b1, "regulator enable level");
      void'(pq.pop_front());
    end
  end

  initial begin
    wait_cyc(6000);
    mismatches++;
    conclude();
  end

  initial begin
    wait_cyc(20);
    aresetn <= 1'b1;
    wait_cyc(10);
    chk_pins(11'h7ff, 11'h66e);
    axi_wr(xcv_pkg::OFS_STATE, 32'h0000_0003);
    axi_wr(8'h14, 32'h0000_0003, xcv_pkg::RESP_SLVERR);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_07ff, 32'h0000_0020);
    axi_rd(xcv_pkg::OFS_CTRL, 32'h0000_0001, 32'h0000_0001);
    axi_rd(8'h10, 32'hffff_ffff, 32'h0000_0000, xcv_pkg::RESP_SLVERR);
    mode(2'h2);
    chk_pins(11'h630, 11'h410);
    mode(2'h3);
    chk_pins(11'h630, 11'h610);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_063f, 32'h0000_0603);
    for (int i = 0; i < 8; i++) begin
      rnd = $random(seed);
      req_txd <= rnd[0];
      bus_in.diff_dom <= ~rnd[0];
      wait_cyc(3);
      chk_pins(11'h580, rnd[0] ? 11'h400 : 11'h180);
    end
    bus_in.diff_dom <= 1'b0;
    axi_wr(xcv_pkg::OFS_IRQ_MASK, 32'h0000_0004);
    req_txd <= 1'b0;
    wait_cyc(TXTO + 16);
    chk_pins(11'h381, 11'h001);
    req_txd <= 1'b1;
    wait_cyc(4);
    axi_wr(xcv_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
    chk_pins(11'h001, 11'h000);
    bus_in.fail_h <= 1'b1;
    wait_cyc(xcv_pkg::FAIL_DELAY_CYC + 20);
    chk_pins(11'h240, 11'h000);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0080, 32'h0000_0080);
    bus_in.fail_h <= 1'b0;
    wait_cyc(xcv_pkg::FAIL_DELAY_CYC + 20);
    chk_pins(11'h040, 11'h040);
    vcc_ok <= 1'b0;
    wait_cyc(8);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0007, 32'h0000_0000);
    vcc_ok <= 1'b1;
    mode(2'h1);
    chk_pins(11'h008, 11'h000);
    // Supply loss lands one edge before the mode pins fall, as on a real board
    req_mode <= 2'h0;
    vcc_ok <= 1'b0;
    wait_cyc(8);
    chk_pins(11'h03e, 11'h020);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0007, 32'h0000_0006);
    wake_in <= 1'b1;
    wait_cyc(8);
    vcc_ok <= 1'b1;
    wait_cyc(8);
    chk_pins(11'h608, 11'h008);
    mode(2'h2);
    chk_pins(11'h600, 11'h200);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0010, 32'h0000_0010);
    mode(2'h3);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0017, 32'h0000_0003);
    mode(2'h1);
    mode(2'h0);
    axi_rd(xcv_pkg::OFS_STATE, 32'h0000_0007, 32'h0000_0006);
    wake_in <= 1'b0;
    wait_cyc(8);
    chk_pins(11'h008, 11'h008);
    vbat_low <= 1'b1;
    wait_cyc(4);
    vbat_low <= 1'b0;
    mode(2'h2);
    chk_pins(11'h200, 11'h000);
    conclude();
  end
endmodule : xcv_mode_ctrl_tb
